/* File: src/spsf_pkg.sv */
// Purpose: Constants for the serial port status flag block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Interrupt flag bits share positions in status, clear and enable words
// Notes on behaviour
// - Block end when bytes reach length plus four
// - Block end interrupt when flag and enable
// - Writing one clears block end flag
// - No smartcard: block end reads zero
// - Timeout flag after programmed idle time
// - Writing one clears timeout flag
// - Timeout interrupt when flag and enable
// - Smartcard uses timeout for wait times
// - Flag only at value plus two samples
// - Counter runs always; flag needs receiver on
// - Enabling after elapse sets flag at once
// - No timeout feature: flag reads zero
// - Flow level flag is inverted pin
// - Pin toggle sets change flag if checking
// - Writing one clears flow change flag
// - Flow change interrupt when flag and enable
// - No flow control: both flags zero
// - Line break detection sets break flag
// - Writing one clears line break flag
// - Line break interrupt when flag and enable
// - Underrun flag reports slave underrun
// - No slave mode: underrun reads zero
package spsf_pkg;
    localparam logic [3:0]  ADR_STATUS     = 4'h0;
    localparam logic [3:0]  ADR_CLEAR      = 4'h4;
    localparam logic [3:0]  ADR_CTRL       = 4'h8;
    localparam logic [3:0]  ADR_TIMING     = 4'hc;
    localparam int          BIT_UNDERRUN   = 13;
    localparam int          BIT_BLOCK_END  = 12;
    localparam int          BIT_TIMEOUT    = 11;
    localparam int          BIT_FLOW_LEVEL = 10;
    localparam int          BIT_FLOW_CHG   = 9;
    localparam int          BIT_BREAK      = 8;
    localparam int          BIT_RX_ON      = 0;
    localparam int          BIT_FLOW_CHECK = 1;
    localparam int          BIT_OVER8      = 2;
    localparam int          BIT_BRK_LONG   = 3;
    localparam int          BIT_SMARTCARD  = 4;
    localparam int          BIT_WAIT_BLOCK = 5;
    localparam int          TMO_LSB        = 0;
    localparam int          TMO_W          = 24;
    localparam int          BLK_LEN_LSB    = 24;
    localparam int          BLK_LEN_W      = 8;
    localparam int          CNT_W          = 30;
    localparam logic [8:0]  BLOCK_EXTRA    = 9'h004;
    localparam logic [29:0] TMO_MARGIN     = 30'h2;
    localparam logic [7:0]  BRK_SHORT_BITS = 8'h0a;
    localparam logic [7:0]  BRK_LONG_BITS  = 8'h0b;
    localparam logic        HAS_SMARTCARD  = 1'b1;
    localparam logic        HAS_TIMEOUT    = 1'b1;
    localparam logic        HAS_FLOW       = 1'b1;
    localparam logic        HAS_SLAVE      = 1'b1;
    localparam logic [31:0] RST_WORD       = 32'h0;
    localparam logic [31:0] MASK_CTRL      = 32'h00001b3f;
endpackage : spsf_pkg

/* File: src/spsf_top.sv */
// Purpose: Status flags of a serial port behind a Wishbone slave
// Assumes: rx and flow pins asynchronous; tick and event inputs on clk_i
// Notes:   Status at 0x0, write-one clear at 0x4, control at 0x8, timing at 0xc
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module spsf_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_pin_i,
    input  wire logic        clear_to_send_n_pin_i,
    input  wire logic        sample_tick_i,
    input  wire logic        block_start_i,
    input  wire logic        rx_byte_i,
    input  wire logic        underrun_i,
    output logic             flow_level_o,
    output logic             irq_o
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [31:0] ctrl;
        logic [31:0] timing;
        logic [2:0]  rx_sync;
        logic        rx_stable;
        logic [2:0]  cts_sync;
        logic        cts_stable;
        logic [29:0] idle_cnt;
        logic        tmo_pending;
        logic [29:0] low_cnt;
        logic        brk_armed;
        logic [8:0]  byte_cnt;
        logic        block_end_flag;
        logic        rx_timeout_flag;
        logic        flow_change_flag;
        logic        line_break_flag;
        logic        slave_underrun_flag;
        logic        flow_level;
        logic        irq;
    } spsf_state_t;

    spsf_state_t s_q;
    spsf_state_t s_d;

    // Samples per bit scaled count; also reused for break length
    function automatic logic [29:0] spsf_scale(input logic [23:0] bits, input logic over8);
        logic [29:0] wide;
        wide = {6'h0, bits};
        spsf_scale = over8 ? (wide << 3) : (wide << 4);
    endfunction : spsf_scale

    function automatic logic [29:0] spsf_sat_inc(input logic [29:0] v);
        spsf_sat_inc = (&v) ? v : v + 30'h1;
    endfunction : spsf_sat_inc

    logic        bus_req;
    logic        wr_clear;
    logic [31:0] clr;
    logic [31:0] status_word;
    logic [29:0] tmo_thr;
    logic [29:0] brk_thr;
    logic [8:0]  blk_target;
    logic        rx_change;
    logic        cts_change;
    logic        smartcard;
    logic [23:0] wait_value;

    always_comb begin
        s_d = s_q;
        bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr_clear = bus_req & wb_we_i & (wb_adr_i == spsf_pkg::ADR_CLEAR);
        clr = wr_clear ? wb_dat_i : 32'h0;
        smartcard = s_q.ctrl[spsf_pkg::BIT_SMARTCARD] & spsf_pkg::HAS_SMARTCARD;
        // Smartcard wait time: char wait uses low byte, block wait the full field
        wait_value = (smartcard & ~s_q.ctrl[spsf_pkg::BIT_WAIT_BLOCK])
                   ? {16'h0, s_q.timing[spsf_pkg::TMO_LSB +: 8]}
                   : s_q.timing[spsf_pkg::TMO_LSB +: spsf_pkg::TMO_W];
        tmo_thr = spsf_scale(wait_value, s_q.ctrl[spsf_pkg::BIT_OVER8])
                + spsf_pkg::TMO_MARGIN;
        brk_thr = spsf_scale({16'h0, s_q.ctrl[spsf_pkg::BIT_BRK_LONG] ? spsf_pkg::BRK_LONG_BITS
                                                                         : spsf_pkg::BRK_SHORT_BITS},
                             s_q.ctrl[spsf_pkg::BIT_OVER8]);
        blk_target = {1'b0, s_q.timing[spsf_pkg::BLK_LEN_LSB +: spsf_pkg::BLK_LEN_W]} + spsf_pkg::BLOCK_EXTRA;

        // Three-stage sync; a change counts once stages two and three agree
        s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin_i};
        s_d.cts_sync = {s_q.cts_sync[1:0], clear_to_send_n_pin_i};
        rx_change = (s_q.rx_sync[2] == s_q.rx_sync[1]) && (s_q.rx_sync[2] != s_q.rx_stable);
        cts_change = (s_q.cts_sync[2] == s_q.cts_sync[1]) && (s_q.cts_sync[2] != s_q.cts_stable);
        if (rx_change) begin
            s_d.rx_stable = s_q.rx_sync[2];
        end
        if (cts_change) begin
            s_d.cts_stable = s_q.cts_sync[2];
        end

        // Bus slave: one-cycle ack, unmapped reads return zero
        s_d.ack = bus_req;
        if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                spsf_pkg::ADR_STATUS: s_d.rdat = status_word;
                spsf_pkg::ADR_CTRL:   s_d.rdat = s_q.ctrl;
                spsf_pkg::ADR_TIMING: s_d.rdat = s_q.timing;
                default:              s_d.rdat = 32'h0;
            endcase
        end
        if (bus_req & wb_we_i) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    if (wb_adr_i == spsf_pkg::ADR_CTRL) begin
                        s_d.ctrl[i*8 +: 8] = wb_dat_i[i*8 +: 8] & spsf_pkg::MASK_CTRL[i*8 +: 8];
                    end
                    if (wb_adr_i == spsf_pkg::ADR_TIMING) begin
                        s_d.timing[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                    end
                end
            end
        end

        // Clears first so a same-cycle hardware set wins
        if (clr[spsf_pkg::BIT_BLOCK_END]) begin
            s_d.block_end_flag = 1'b0;
        end
        if (clr[spsf_pkg::BIT_TIMEOUT]) begin
            s_d.rx_timeout_flag = 1'b0;
        end
        if (clr[spsf_pkg::BIT_FLOW_CHG]) begin
            s_d.flow_change_flag = 1'b0;
        end
        if (clr[spsf_pkg::BIT_BREAK]) begin
            s_d.line_break_flag = 1'b0;
        end
        if (clr[spsf_pkg::BIT_UNDERRUN]) begin
            s_d.slave_underrun_flag = 1'b0;
        end

        // Block length: count includes the prologue bytes
        if (block_start_i) begin
            s_d.byte_cnt = 9'h0;
        end else if (rx_byte_i) begin
            s_d.byte_cnt = (&s_q.byte_cnt) ? s_q.byte_cnt : s_q.byte_cnt + 9'h1;
            if (s_d.byte_cnt >= blk_target && smartcard) begin
                s_d.block_end_flag = 1'b1;
            end
        end

        // Idle counter runs regardless of rx_on, restarts on line activity
        if (~s_q.rx_stable | rx_change) begin
            s_d.idle_cnt = 30'h0;
            s_d.tmo_pending = 1'b0;
        end else if (sample_tick_i) begin
            s_d.idle_cnt = spsf_sat_inc(s_q.idle_cnt);
            if (s_d.idle_cnt == tmo_thr) begin
                s_d.tmo_pending = 1'b1;
            end
        end
        // Pending elapse waits for rx_on, so late enabling still flags
        if (s_q.tmo_pending & s_q.ctrl[spsf_pkg::BIT_RX_ON] & spsf_pkg::HAS_TIMEOUT) begin
            s_d.rx_timeout_flag = 1'b1;
            s_d.tmo_pending = 1'b0;
        end

        // Break: line low for the break length; one flag per low period
        if (s_q.rx_stable) begin
            s_d.low_cnt = 30'h0;
            s_d.brk_armed = 1'b1;
        end else if (sample_tick_i) begin
            s_d.low_cnt = spsf_sat_inc(s_q.low_cnt);
            if (s_q.brk_armed && s_d.low_cnt >= brk_thr) begin
                s_d.line_break_flag = 1'b1;
                s_d.brk_armed = 1'b0;
            end
        end

        if (cts_change & s_q.ctrl[spsf_pkg::BIT_FLOW_CHECK] & spsf_pkg::HAS_FLOW) begin
            s_d.flow_change_flag = 1'b1;
        end
        if (underrun_i & spsf_pkg::HAS_SLAVE) begin
            s_d.slave_underrun_flag = 1'b1;
        end

        s_d.flow_level = ~s_q.cts_stable & spsf_pkg::HAS_FLOW;
        s_d.irq = (s_q.block_end_flag & s_q.ctrl[spsf_pkg::BIT_BLOCK_END])
                | (s_q.rx_timeout_flag & s_q.ctrl[spsf_pkg::BIT_TIMEOUT])
                | (s_q.flow_change_flag & s_q.ctrl[spsf_pkg::BIT_FLOW_CHG])
                | (s_q.line_break_flag & s_q.ctrl[spsf_pkg::BIT_BREAK]);
    end

    // Absent features read as zero
    always_comb begin
        status_word = 32'h0;
        status_word[spsf_pkg::BIT_UNDERRUN] = s_q.slave_underrun_flag & spsf_pkg::HAS_SLAVE;
        status_word[spsf_pkg::BIT_BLOCK_END] = s_q.block_end_flag & spsf_pkg::HAS_SMARTCARD;
        status_word[spsf_pkg::BIT_TIMEOUT] = s_q.rx_timeout_flag & spsf_pkg::HAS_TIMEOUT;
        status_word[spsf_pkg::BIT_FLOW_LEVEL] = s_q.flow_level;
        status_word[spsf_pkg::BIT_FLOW_CHG] = s_q.flow_change_flag & spsf_pkg::HAS_FLOW;
        status_word[spsf_pkg::BIT_BREAK] = s_q.line_break_flag;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.rx_sync <= 3'h7;
            s_q.rx_stable <= 1'b1;
            s_q.cts_sync <= 3'h7;
            s_q.cts_stable <= 1'b1;
            s_q.ctrl <= spsf_pkg::RST_WORD;
            s_q.timing <= spsf_pkg::RST_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign flow_level_o = s_q.flow_level;
    assign irq_o = s_q.irq;
endmodule : spsf_top

/* File: test/spsf_peer.sv */
// Purpose: Serial line and flow-control peer
// Assumes: Receive line idles high
// Notes:   Drives only on clock edges
`timescale 1ns/100ps
module spsf_peer (
    input  wire logic clk_i,
    output logic      rx_o,
    output logic      clear_to_send_n_o
);
    initial begin
        rx_o = 1'b1;
        clear_to_send_n_o = 1'b1;
    end
    task automatic line_low(input int n);
        rx_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask : line_low
    task automatic allow_send(input logic on);
        clear_to_send_n_o <= ~on;
    endtask : allow_send
endmodule : spsf_peer

/* File: test/spsf_sva.sv */
// Purpose: Port-level checks for spsf_top
// Assumes: One clock, synchronous reset
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module spsf_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        clear_to_send_n_pin_i,
    input wire logic        flow_level_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
    a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) != 4'h0 &&
        $past(wb_adr_i) != 4'h4 && $past(wb_adr_i) != 4'h8 && $past(wb_adr_i) != 4'hc |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_flow_low: assert property (!clear_to_send_n_pin_i [*7] |=> flow_level_o) else $error("flow level low");
    a_flow_high: assert property (clear_to_send_n_pin_i [*7] |=> !flow_level_o) else $error("flow level high");
    a_status_level: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0 &&
        $stable(flow_level_o) && $past(flow_level_o, 3) == flow_level_o |-> wb_dat_o[10] == flow_level_o)
        else $error("status flow bit differs");
    a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !flow_level_o && !wb_ack_o)
        else $error("outputs active after reset");
    a_irq_sticky: assert property ($fell(irq_o) |-> $past(wb_we_i) || $past(wb_we_i, 2) ||
        $past(wb_we_i, 3)) else $error("irq dropped without a write");
endmodule : spsf_sva

/* File: test/spsf_top_tb.sv */
// Purpose: Self-checking bench for spsf_top
// Assumes: Ticks driven by the bench, one per cycle when on
// Notes:   Status reads wait for pin synchronisers
`timescale 1ns/100ps
module spsf_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, rx_pin, cts_n, flow_level_o, irq_o;
    logic        sample_tick_i = 1'b0, block_start_i = 1'b0, rx_byte_i = 1'b0, underrun_i = 1'b0;
    int          fail_count = 0, samples_checked = 0, cycles = 0;
    spsf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_pin_i(rx_pin), .clear_to_send_n_pin_i(cts_n), .sample_tick_i(sample_tick_i),
        .block_start_i(block_start_i), .rx_byte_i(rx_byte_i), .underrun_i(underrun_i),
        .flow_level_o(flow_level_o), .irq_o(irq_o));
    spsf_peer peer (.clk_i(clk_i), .rx_o(rx_pin), .clear_to_send_n_o(cts_n));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Settling time covers the pin synchronisers
    task automatic stat_chk(input logic [31:0] mask, input logic [31:0] exp);
        repeat (8) @(posedge clk_i);
        xfer(1'b0, spsf_pkg::ADR_STATUS, 32'h0);
        chk(rd & mask, exp);
    endtask : stat_chk
    task automatic clr(input logic [31:0] d);
        xfer(1'b1, spsf_pkg::ADR_CLEAR, d);
    endtask : clr
    task automatic ctl(input logic [31:0] d);
        xfer(1'b1, spsf_pkg::ADR_CTRL, d);
    endtask : ctl
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        sample_tick_i <= 1'b1;
        xfer(1'b0, spsf_pkg::ADR_CTRL, 32'h0);
        chk(rd, spsf_pkg::RST_WORD);
        xfer(1'b1, spsf_pkg::ADR_TIMING, 32'h02000001);
        repeat (40) @(posedge clk_i);
        stat_chk(32'h3f00, 32'h0);
        sample_tick_i <= 1'b0;
        ctl(32'h0801);
        stat_chk(32'h0800, 32'h0800);
        chk({31'h0, irq_o}, 32'h1);
        clr(32'h0);
        stat_chk(32'h0800, 32'h0800);
        clr(32'h0800);
        stat_chk(32'h0800, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        for (int m = 0; m < 2; m++) begin
            ctl(32'h0801 | (32'(m) << 2));
            peer.line_low(2);
            repeat (8) @(posedge clk_i);
            sample_tick_i <= 1'b1;
            repeat (m ? 9 : 17) @(posedge clk_i);
            sample_tick_i <= 1'b0;
            stat_chk(32'h0800, 32'h0);
            sample_tick_i <= 1'b1;
            @(posedge clk_i);
            sample_tick_i <= 1'b0;
            stat_chk(32'h0800, 32'h0800);
            clr(32'h0800);
        end
        // Char wait sees only the low byte, block wait the whole value
        xfer(1'b1, spsf_pkg::ADR_TIMING, 32'h02000101);
        for (int w = 0; w < 2; w++) begin
            ctl(32'h0811 | (32'(w) << 5));
            peer.line_low(2);
            repeat (8) @(posedge clk_i);
            sample_tick_i <= 1'b1;
            repeat (18) @(posedge clk_i);
            sample_tick_i <= 1'b0;
            stat_chk(32'h0800, w ? 32'h0 : 32'h0800);
            clr(32'h0800);
        end
        ctl(32'h1011);
        block_start_i <= 1'b1;
        @(posedge clk_i);
        block_start_i <= 1'b0;
        rx_byte_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rx_byte_i <= 1'b0;
        stat_chk(32'h1000, 32'h0);
        rx_byte_i <= 1'b1;
        @(posedge clk_i);
        rx_byte_i <= 1'b0;
        stat_chk(32'h1000, 32'h1000);
        chk({31'h0, irq_o}, 32'h1);
        clr(32'h1000);
        stat_chk(32'h1000, 32'h0);
        ctl(32'h0202);
        peer.allow_send(1'b1);
        stat_chk(32'h0600, 32'h0600);
        chk({31'h0, irq_o}, 32'h1);
        chk({31'h0, flow_level_o}, 32'h1);
        clr(32'h0200);
        stat_chk(32'h0600, 32'h0400);
        ctl(32'h0200);
        peer.allow_send(1'b0);
        stat_chk(32'h0600, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        chk({31'h0, flow_level_o}, 32'h0);
        // 166 low ticks: below the 11-bit length, above the 10-bit one
        for (int b = 0; b < 2; b++) begin
            ctl(b ? 32'h0101 : 32'h0109);
            sample_tick_i <= 1'b1;
            peer.line_low(170);
            sample_tick_i <= 1'b0;
            stat_chk(32'h0100, b ? 32'h0100 : 32'h0);
        end
        chk({31'h0, irq_o}, 32'h1);
        clr(32'h0100);
        stat_chk(32'h0100, 32'h0);
        underrun_i <= 1'b1;
        @(posedge clk_i);
        underrun_i <= 1'b0;
        stat_chk(32'h2000, 32'h2000);
        clr(32'h2000);
        stat_chk(32'h3f00, 32'h0);
        // Only the selected low byte may change
        wb_sel_i <= 4'h1;
        ctl(32'hffffffff);
        xfer(1'b0, spsf_pkg::ADR_CTRL, 32'h0);
        chk(rd, 32'h0000013f);
        wb_sel_i <= 4'hf;
        ctl(32'hffffffff);
        xfer(1'b0, spsf_pkg::ADR_CTRL, 32'h0);
        chk(rd, spsf_pkg::MASK_CTRL);
        xfer(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        test_done();
    end
endmodule : spsf_top_tb
bind spsf_top spsf_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .clear_to_send_n_pin_i(clear_to_send_n_pin_i), .flow_level_o(flow_level_o), .irq_o(irq_o));
